// [burst_order_map.sv]
// Purpose: Column of one beat within a burst from start column, burst type and beat number
// Assumes: Purely combinational; caller masks beats that are not driven
// Notes: Sequential wraps inside the nibble, interleaved is a plain XOR
`timescale 1ns/1ps
module burst_order_map (
  // Burst position
  input wire logic [2:0] start_col,
  input wire logic interleaved,
  input wire logic [2:0] beat,
  // Resulting column
  output logic [2:0] col
);

  logic [1:0] wrap_low;

  assign wrap_low = start_col[1:0] + beat[1:0];
  assign col = interleaved ? (start_col ^ beat) : {start_col[2] ^ beat[2], wrap_low};

endmodule

// [ddr_ctrl_model.sv]
// Purpose: Behavioural memory controller driving the command and address pins
// Assumes: Commands launch 1 ns after a rising edge and stand for one clock
// Notes: Deselect cycles show the inverse address so a stale command never looks fresh
`timescale 1ns/1ps
module ddr_ctrl_model #(
  parameter int MRD_CLKS = 4,
  parameter int MOD_CLKS = 12,
  parameter int DLLK_CLKS = 64
) (
  // Clock
  input wire logic sys_clk,
  // Command pins
  output mode_pkg::pins_t pins
);
  initial pins = mode_pkg::PINS_IDLE;

  // Returns one clock after the launch, 1 ns past the edge
  task automatic step(input mode_pkg::pins_t p);
    @(posedge sys_clk);
    #1;
    pins = p;
    @(posedge sys_clk);
    #1;
    pins.cs_n = 1'b1;
    pins.addr = ~p.addr;
  endtask

  // whole word, reserved and test bits low
  task automatic mrs(input logic [2:0] bank, input logic cke, input logic [15:0] w);
    mode_pkg::pins_t p;
    p = '{cke: cke, cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0,
          ba: {1'b0, bank[1:0]}, addr: {3'h0, w[12:8], 1'b0, w[6:0]}};
    step(p);
    repeat (MRD_CLKS + MOD_CLKS) @(posedge sys_clk);
    // lock wait after a DLL reset
    if (w[8]) repeat (DLLK_CLKS) @(posedge sys_clk);
    #1;
  endtask

  // read or write; bit 12 picks the size per command
  task automatic rw(input logic wr, input logic [2:0] col, input logic a12, input logic ap);
    mode_pkg::pins_t p;
    p = '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0, we_n: ~wr, ba: 3'h0,
          addr: 16'h0000};
    p.addr[mode_pkg::CHOP_SEL_BIT] = a12;
    p.addr[mode_pkg::AUTO_PRE_BIT] = ap;
    p.addr[2:0] = col;
    step(p);
  endtask
endmodule

// [mr0_bank.sv]
// Purpose: Mode register zero of a DDR3 device and the burst, latency and recovery it sets
// Assumes: Pins arrive from outside and are synchronised; AL, CWL and tRP come from elsewhere
// Notes: Two beats per clock, four clocks per full burst; data path itself is outside
//
// Summary of operation
// - Load only on mode register set: CS, RAS, CAS, WE and bank bits low.
// - Write recovery plus row precharge sets auto-precharge write to activate interval.
// - Write recovery code comes from address bits 9 to 11.
// - Address bit 3 selects sequential (0) or interleaved (1) read beat order.
// - Address bits 0 and 1 pick fixed chop, fixed eight, or per-command.
// - Per-command mode samples address bit 12 at each read or write.
// - Sequential eight-beat read wraps inside starting nibble, then the other nibble.
// - Interleaved eight-beat read orders beat n as start column XOR n.
// - Chopped read gives four beats; outputs stay off for remaining slots.
// - Chopped write uses column bit 2 only, ascending; last four slots ignored.
// - Eight-beat write ignores all three column bits and stores beats ascending from column zero.
// - Fixed chop starts write recovery two clocks earlier; per-command chop does not.
// - CAS latency is whole clocks from internal read to first data.
// - First read data appears at additive latency plus CAS latency.
// - DLL reset bit clears itself once the reset has been issued.
`timescale 1ns/1ps
module sdram_mode_register_zero #(
  parameter int SLOT_AW = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Command and address pins
  input wire mode_pkg::pins_t pins,
  // Latencies held by the other mode registers
  input wire logic [3:0] al_cycles,
  input wire logic [3:0] cwl_cycles,
  input wire logic [4:0] trp_cycles,
  // Register contents and decoded values
  output mode_pkg::mode_t mode_ff,
  output logic [4:0] cl_cycles_ff,
  output logic [4:0] wr_cycles_ff,
  output logic dll_reset_pulse_ff,
  // Burst data slots
  output logic rd_oe_ff,
  output logic wr_take_ff,
  output mode_pkg::beat_pair_t beat_pair_ff,
  // Recovery timing
  output logic wtr_start_ff,
  output logic act_block_ff
);

  localparam int SLOT_DEPTH = 2 ** SLOT_AW;

  mode_pkg::pins_t pin_meta_ff;
  mode_pkg::pins_t pin_ff;
  mode_pkg::mode_t mrs_word;
  mode_pkg::cmd_rec_t new_rec;
  mode_pkg::cmd_rec_t fire_rec;
  mode_pkg::cmd_rec_t cur_ff;
  mode_pkg::cmd_rec_t slot_mem [SLOT_DEPTH];
  logic cmd_sel;
  logic mrs_hit;
  logic rd_cmd;
  logic wr_cmd;
  logic fire;
  logic [2:0] fire_col;
  logic [5:0] lat_sum;
  logic [SLOT_AW-1:0] now_ff;
  logic [SLOT_AW-1:0] sched_idx;
  logic [1:0] clk_ff;
  logic active_ff;
  logic data_clk;
  logic [2:0] map_start;
  logic map_il;
  logic [2:0] lane_col [2];
  logic rec_point;
  logic [5:0] dal_total;
  logic [5:0] dal_cnt_ff;
  logic [15:0] kept_bits;
  logic [2:0] wr_code_now;

  // Pins come from another chip; two stages before any decode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_ff <= mode_pkg::PINS_IDLE;
      pin_ff <= mode_pkg::PINS_IDLE;
    end else begin
      pin_meta_ff <= pins;
      pin_ff <= pin_meta_ff;
    end
  end

  assign cmd_sel = pin_ff.cke && !pin_ff.cs_n;
  assign mrs_hit = cmd_sel && !pin_ff.ras_n && !pin_ff.cas_n && !pin_ff.we_n &&
                   (pin_ff.ba == mode_pkg::BA_MODE_ZERO);
  assign rd_cmd = cmd_sel && pin_ff.ras_n && !pin_ff.cas_n && pin_ff.we_n;
  assign wr_cmd = cmd_sel && pin_ff.ras_n && !pin_ff.cas_n && !pin_ff.we_n;
  assign mrs_word = mode_pkg::mode_t'(pin_ff.addr);
  assign wr_code_now = mrs_word.wr_code;

  // DLL reset self-clear; a new load in the same cycle wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= mode_pkg::MODE_RESET;
    end else if (mrs_hit) begin
      mode_ff <= mrs_word;
    end else begin
      mode_ff.dll_reset <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cl_cycles_ff <= 5'h00;
      wr_cycles_ff <= 5'h00;
      dll_reset_pulse_ff <= 1'b0;
    end else begin
      dll_reset_pulse_ff <= mrs_hit && mrs_word.dll_reset;
      if (mrs_hit) begin
        cl_cycles_ff <= mode_pkg::cl_decode(mrs_word.cl_code);
        wr_cycles_ff <= mode_pkg::wr_decode(mrs_word.wr_code);
      end
    end
  end

  // per-command chop from address bit 12
  always_comb begin
    new_rec.valid = 1'b1;
    new_rec.is_write = wr_cmd;
    new_rec.auto_pre = pin_ff.addr[mode_pkg::AUTO_PRE_BIT];
    new_rec.col = pin_ff.addr[2:0];
    new_rec.chop = (mode_ff.burst_len == mode_pkg::BL_FIXED_CHOP) ||
                   ((mode_ff.burst_len == mode_pkg::BL_ON_THE_FLY) &&
                    !pin_ff.addr[mode_pkg::CHOP_SEL_BIT]);
  end

  // read latency is AL plus CL
  assign lat_sum = wr_cmd ? ({2'h0, al_cycles} + {2'h0, cwl_cycles}) :
                            ({2'h0, al_cycles} + {1'b0, cl_cycles_ff});
  // Scheduled early by the engine's own pipeline depth
  assign sched_idx = now_ff + lat_sum[SLOT_AW-1:0] - SLOT_AW'(mode_pkg::LAT_PIPE);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      now_ff <= '0;
    end else begin
      now_ff <= now_ff + SLOT_AW'(1);
    end
  end

  // Time wheel: each slot holds the command that starts its burst then.
  // Two commands landing on one slot is a controller spacing fault; the later wins.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < SLOT_DEPTH; i++) begin
        slot_mem[i] <= '0;
      end
    end else begin
      slot_mem[now_ff].valid <= 1'b0;
      if (rd_cmd || wr_cmd) begin
        slot_mem[sched_idx] <= new_rec;
      end
    end
  end

  assign fire_rec = slot_mem[now_ff];
  assign fire = fire_rec.valid;
  assign fire_col = fire_rec.col;

  // A new burst may cut in seamlessly at four-clock spacing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
      clk_ff <= 2'h0;
      active_ff <= 1'b0;
    end else if (fire) begin
      cur_ff <= fire_rec;
      clk_ff <= 2'h0;
      active_ff <= 1'b1;
    end else if (active_ff) begin
      clk_ff <= clk_ff + 2'h1;
      if (clk_ff == mode_pkg::BURST_LAST_CLK) begin
        active_ff <= 1'b0;
      end
    end
  end

  // burst type steers read order only
  // chopped write start at nibble base
  // full write always from column zero
  always_comb begin
    if (cur_ff.is_write) begin
      map_start = cur_ff.chop ? {cur_ff.col[2], 2'h0} : 3'h0;
      map_il = 1'b0;
    end else begin
      map_start = cur_ff.col;
      map_il = mode_ff.burst_type;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_lane
    burst_order_map u_map (
      .start_col(map_start),
      .interleaved(map_il),
      .beat({clk_ff, 1'(g)}),
      .col(lane_col[g])
    );
  end

  // chopped bursts leave the last two clocks undriven
  assign data_clk = active_ff && (!cur_ff.chop || (clk_ff < mode_pkg::CHOP_DATA_CLKS));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_oe_ff <= 1'b0;
      wr_take_ff <= 1'b0;
      beat_pair_ff <= '0;
    end else begin
      rd_oe_ff <= data_clk && !cur_ff.is_write;
      wr_take_ff <= data_clk && cur_ff.is_write;
      beat_pair_ff <= {lane_col[1], lane_col[0]};
    end
  end

  // fixed chop ends the internal write two clocks sooner
  assign rec_point = active_ff && cur_ff.is_write &&
                     (clk_ff == ((mode_ff.burst_len == mode_pkg::BL_FIXED_CHOP) ?
                                 mode_pkg::CHOP_LAST_CLK : mode_pkg::BURST_LAST_CLK));
  assign dal_total = {1'b0, wr_cycles_ff} + {1'b0, trp_cycles};

  // activation held off for WR plus tRP
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wtr_start_ff <= 1'b0;
      dal_cnt_ff <= 6'h00;
      act_block_ff <= 1'b0;
    end else begin
      wtr_start_ff <= rec_point;
      if (rec_point && cur_ff.auto_pre) begin
        dal_cnt_ff <= dal_total;
        act_block_ff <= 1'b1;
      end else if (dal_cnt_ff != 6'h00) begin
        dal_cnt_ff <= dal_cnt_ff - 6'h01;
        act_block_ff <= (dal_cnt_ff != 6'h01);
      end
    end
  end

  assign kept_bits = mode_ff & ~mode_pkg::DLL_RESET_MASK;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_MRS_LOAD: assert property (mrs_hit |=> mode_ff == $past(mrs_word))
    else $error("mode register not loaded from address pins");
  AST_FIELDS_HELD: assert property (!mrs_hit |=> $stable(kept_bits))
    else $error("mode field changed without a load");
  AST_DLL_CLEAR: assert property (mode_ff.dll_reset && !mrs_hit |=> !mode_ff.dll_reset)
    else $error("DLL reset bit did not clear");
  AST_WR_DECODE: assert property (mrs_hit |=>
      wr_cycles_ff == mode_pkg::wr_decode($past(wr_code_now)))
    else $error("write recovery not taken from bits 9 to 11");
  AST_OTF_CHOP: assert property ((rd_cmd || wr_cmd) &&
      mode_ff.burst_len == mode_pkg::BL_ON_THE_FLY |-> new_rec.chop == !pin_ff.addr[12])
    else $error("per-command chop not sampled from bit 12");
  AST_READ_LATENCY: assert property (rd_cmd && lat_sum == 6'h05 |-> ##5 rd_oe_ff)
    else $error("read data not at AL plus CL");
  AST_SEQ_ORDER: assert property (fire && !fire_rec.is_write && !mode_ff.burst_type |-> ##2
      beat_pair_ff.col0 == $past(fire_col, 2) &&
      beat_pair_ff.col1[1:0] == 2'($past(fire_col[1:0], 2) + 2'h1))
    else $error("sequential read order wrong");
  AST_IL_ORDER: assert property (fire && !fire_rec.is_write && mode_ff.burst_type &&
      !fire_rec.chop ##1 !fire [*2] |-> ##2
      beat_pair_ff.col0 == ($past(fire_col, 4) ^ 3'h4) &&
      beat_pair_ff.col1 == ($past(fire_col, 4) ^ 3'h5))
    else $error("interleaved read order wrong");
  AST_CHOP_HIZ: assert property (fire && !fire_rec.is_write && fire_rec.chop
      ##1 !fire [*2] |-> ##2 !rd_oe_ff)
    else $error("chopped read drove a trailing slot");
  AST_CHOP_WRITE: assert property (fire && fire_rec.is_write && fire_rec.chop |-> ##2
      wr_take_ff && beat_pair_ff.col0 == {$past(fire_col[2], 2), 2'h0})
    else $error("chopped write start wrong");
  AST_FULL_WRITE: assert property (fire && fire_rec.is_write && !fire_rec.chop |-> ##2
      beat_pair_ff.col0 == 3'h0 && beat_pair_ff.col1 == 3'h1)
    else $error("eight-beat write not ascending");
  AST_CHOP_REC_EARLY: assert property (fire && fire_rec.is_write &&
      mode_ff.burst_len == mode_pkg::BL_FIXED_CHOP ##1 !fire |-> ##1 rec_point)
    else $error("fixed chop recovery not pulled in");
  AST_OTF_REC_LATE: assert property (fire && fire_rec.is_write &&
      mode_ff.burst_len != mode_pkg::BL_FIXED_CHOP ##1 !fire [*3] |-> ##1 rec_point)
    else $error("recovery start not at burst end");
  AST_DAL_LOAD: assert property (rec_point && cur_ff.auto_pre |=>
      act_block_ff && dal_cnt_ff == $past(dal_total))
    else $error("activate hold not WR plus tRP");

endmodule

// [mr0_bank_tb.sv]
// Purpose: Self-checking bench for mode register zero and the bursts it shapes
// Assumes: Pins reach decode two edges after launch
// Notes: Latencies are counted from the return of the command task
`timescale 1ns/1ps
module sdram_mode_register_zero_tb;
  localparam int SYNC = 2;
  logic sys_clk;
  logic arst_n;
  mode_pkg::pins_t pins;
  logic [3:0] al_cycles;
  logic [3:0] cwl_cycles;
  logic [4:0] trp_cycles;
  mode_pkg::mode_t mode_ff;
  logic [4:0] cl_cycles_ff;
  logic [4:0] wr_cycles_ff;
  logic dll_reset_pulse_ff;
  logic rd_oe_ff;
  logic wr_take_ff;
  mode_pkg::beat_pair_t beat_pair_ff;
  logic wtr_start_ff;
  logic act_block_ff;
  logic [4:0] wr_exp [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h10};
  int miscompares;
  int checks;
  int pulses;
  int dll_bits;

  ddr_ctrl_model ddr_ctrl_model_inst (.sys_clk(sys_clk), .pins(pins));
  sdram_mode_register_zero #(.SLOT_AW(5)) sdram_mode_register_zero_inst (.sys_clk(sys_clk),
    .arst_n(arst_n), .pins(pins), .al_cycles(al_cycles), .cwl_cycles(cwl_cycles),
    .trp_cycles(trp_cycles), .mode_ff(mode_ff), .cl_cycles_ff(cl_cycles_ff),
    .wr_cycles_ff(wr_cycles_ff), .dll_reset_pulse_ff(dll_reset_pulse_ff), .rd_oe_ff(rd_oe_ff),
    .wr_take_ff(wr_take_ff), .beat_pair_ff(beat_pair_ff), .wtr_start_ff(wtr_start_ff),
    .act_block_ff(act_block_ff));

  always #2.5 sys_clk = ~sys_clk;

  // Old values are seen here, so each high cycle counts once
  always @(posedge sys_clk) begin
    if (dll_reset_pulse_ff === 1'b1) pulses++;
    if (mode_ff.dll_reset === 1'b1) dll_bits++;
  end

  task automatic end_sim();
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic load(input logic [1:0] bl, input logic bt, input logic [2:0] clc,
                      input logic [2:0] wrc, input logic dll);
    logic [15:0] w;
    int p0;
    int d0;
    w = {4'h0, wrc, dll, 1'b0, clc, bt, 1'b0, bl};
    p0 = pulses;
    d0 = dll_bits;
    ddr_ctrl_model_inst.mrs(3'h0, 1'b1, w);
    chk("mode", w & ~mode_pkg::DLL_RESET_MASK, mode_ff);
    chk("cl", 16'(clc) + 16'h0004, 16'(cl_cycles_ff));
    chk("dll pulses", 16'(dll), 16'(pulses - p0));
    chk("dll bit", 16'(dll), 16'(dll_bits - d0));
  endtask

  task automatic burst(input logic wr, input logic chop, input logic il, input logic [2:0] col,
                       input logic a12, input int lat);
    int n;
    logic [2:0] b;
    logic [2:0] e;
    ddr_ctrl_model_inst.rw(wr, col, a12, 1'b0);
    n = 0;
    while (n < 64 && (wr ? wr_take_ff : rd_oe_ff) !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 64) begin
      miscompares++;
      end_sim();
    end
    chk("latency", 16'(lat + SYNC - 1), 16'(n));
    for (int k = 0; k < 4; k++) begin
      chk("slot", 16'(k < 2 || !chop), 16'(wr ? wr_take_ff : rd_oe_ff));
      for (int h = 0; h < 2; h++) begin
        b = 3'(2 * k + h);
        if (wr) e = chop ? {col[2], b[1:0]} : b;
        else if (il) e = col ^ b;
        else e = {col[2] ^ b[2], col[1:0] + b[1:0]};
        if (k < 2 || !chop) begin
          chk("beat", 16'(e), 16'(h ? beat_pair_ff.col1 : beat_pair_ff.col0));
        end
      end
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic recover(input logic a12, input int lat, input int first, input int wrv);
    int wtr_at;
    int act_at;
    int act_len;
    wtr_at = -1;
    act_at = -1;
    act_len = 0;
    ddr_ctrl_model_inst.rw(1'b1, 3'h0, a12, 1'b1);
    for (int n = 0; n < 60; n++) begin
      if (wtr_start_ff === 1'b1 && wtr_at < 0) wtr_at = n;
      if (act_block_ff === 1'b1) begin
        if (act_at < 0) act_at = n;
        act_len++;
      end
      @(posedge sys_clk);
      #1;
    end
    chk("wtr start", 16'(lat + SYNC - 1 + first), 16'(wtr_at));
    chk("act start", 16'(wtr_at), 16'(act_at));
    chk("act len", 16'(wrv) + 16'(trp_cycles), 16'(act_len));
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    al_cycles = 4'h0;
    cwl_cycles = 4'h5;
    trp_cycles = 5'h03;
    miscompares = 0;
    checks = 0;
    pulses = 0;
    dll_bits = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    chk("reset mode", mode_pkg::MODE_RESET, mode_ff);
    for (int c = 0; c < 8; c++) begin
      load(mode_pkg::BL_FIXED_EIGHT, 1'b0, 3'(c), 3'(c), 1'(c == 3));
      chk("wr", 16'(wr_exp[c]), 16'(wr_cycles_ff));
    end
    ddr_ctrl_model_inst.mrs(3'h1, 1'b1, 16'h0A55);
    ddr_ctrl_model_inst.mrs(3'h0, 1'b0, 16'h0A55);
    chk("ignored", 16'h0E70, mode_ff);
    // write recovery code 1 covers a recovery of five clocks
    for (int t = 0; t < 2; t++) begin
      load(mode_pkg::BL_FIXED_EIGHT, 1'(t), 3'h1, 3'h1, 1'b0);
      for (int c = 0; c < 8; c++) begin
        burst(1'b0, 1'b0, 1'(t), 3'(c), 1'b0, 5);
        burst(1'b1, 1'b0, 1'(t), 3'(c), 1'b0, 5);
      end
    end
    al_cycles = 4'h2;
    load(mode_pkg::BL_FIXED_CHOP, 1'b1, 3'h1, 3'h1, 1'b0);
    for (int c = 0; c < 8; c += 3) begin
      burst(1'b0, 1'b1, 1'b1, 3'(c), 1'b1, 7);
      burst(1'b1, 1'b1, 1'b1, 3'(c), 1'b1, 7);
    end
    recover(1'b1, 7, 1, 5);
    load(mode_pkg::BL_ON_THE_FLY, 1'b0, 3'h1, 3'h1, 1'b0);
    burst(1'b0, 1'b1, 1'b0, 3'h5, 1'b0, 7);
    burst(1'b0, 1'b0, 1'b0, 3'h5, 1'b1, 7);
    burst(1'b1, 1'b1, 1'b0, 3'h6, 1'b0, 7);
    recover(1'b0, 7, 3, 5);
    load(mode_pkg::BL_FIXED_EIGHT, 1'b0, 3'h1, 3'h6, 1'b0);
    recover(1'b0, 7, 3, 12);
    end_sim();
  end
endmodule

// [mr0_pkg.sv]
// Purpose: Shared constants, field layout and carrier types for the mode register zero bank
// Assumes: One 200 MHz clock; command pins are sampled once per clock
// Notes: Encodings of burst length, CAS latency and write recovery live here only
package mode_pkg;

  // Burst length field encodings
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;

  // Bank address that selects this register
  localparam logic [2:0] BA_MODE_ZERO = 3'h0;

  // No defined contents after power-up; zero is chosen for determinism
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] DLL_RESET_MASK = 16'h0100;

  // Command pin positions
  localparam int CHOP_SEL_BIT = 12;
  localparam int AUTO_PRE_BIT = 10;

  // CAS latency code offset in clocks
  localparam logic [4:0] CL_OFFSET = 5'h04;

  // Burst engine timing, in clocks of the burst
  localparam logic [1:0] BURST_LAST_CLK = 2'h3;
  localparam logic [1:0] CHOP_LAST_CLK = 2'h1;
  localparam logic [1:0] CHOP_DATA_CLKS = 2'h2;
  localparam int LAT_PIPE = 2;

  // Idle pin level: clock enable low, all active-low strobes high
  localparam logic [23:0] PINS_IDLE = 24'h780000;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } pins_t;

  typedef struct packed {
    logic [2:0] reserved_field;
    logic ppd_fast_exit;
    logic [2:0] wr_code;
    logic dll_reset;
    logic test_mode;
    logic [2:0] cl_code;
    logic burst_type;
    logic cl_low;
    logic [1:0] burst_len;
  } mode_t;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic chop;
    logic auto_pre;
    logic [2:0] col;
  } cmd_rec_t;

  typedef struct packed {
    logic [2:0] col1;
    logic [2:0] col0;
  } beat_pair_t;

  function automatic logic [4:0] wr_decode(input logic [2:0] code);
    case (code)
      3'h1: wr_decode = 5'h05;
      3'h2: wr_decode = 5'h06;
      3'h3: wr_decode = 5'h07;
      3'h4: wr_decode = 5'h08;
      3'h5: wr_decode = 5'h0A;
      3'h6: wr_decode = 5'h0C;
      default: wr_decode = 5'h10;
    endcase
  endfunction

  function automatic logic [4:0] cl_decode(input logic [2:0] code);
    cl_decode = {2'h0, code} + CL_OFFSET;
  endfunction

endpackage
